// ### logic/key_store_pkg.sv
// key store: shared constants, register map and state carrier.
// assumes a 32-bit avalon-mm slave with byte addresses.
package key_store_pkg;

    localparam int KEY_W = 128;
    localparam int MEM_N = 72;  // 8 banks of 8, plus 8 default slots

    // register byte offsets
    localparam logic [7:0] OFS_SEL  = 8'h00;
    localparam logic [7:0] OFS_CMD  = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [3:0] PAGE_KIN  = 4'h1;  // 0x10..0x1c key input
    localparam logic [3:0] PAGE_KOUT = 4'h2;  // 0x20..0x2c key output

    // selector register fields
    localparam int SEL_TYPE  = 0;
    localparam int SEL_NUM   = 4;
    localparam int SEL_DEST  = 8;
    localparam int SEL_DEFIX = 12;
    localparam int SEL_STORE = 16;
    localparam int SEL_DEF   = 17;
    localparam int SEL_W     = 18;

    // command opcodes, bits 3:0 of the command word, argument 7:4
    localparam logic [3:0] OP_LOOKUP = 4'h1;
    localparam logic [3:0] OP_STORE  = 4'h2;
    localparam logic [3:0] OP_ERASE  = 4'h3;
    localparam logic [3:0] OP_ALLOC  = 4'h4;
    localparam logic [3:0] OP_AUTH   = 4'h5;
    localparam logic [3:0] OP_WIPE   = 4'h6;
    localparam logic [3:0] OP_REJECT = 4'h7;

    // key type codes
    localparam logic [3:0] TY_USER    = 4'h1;
    localparam logic [3:0] TY_ACCESS  = 4'h2;
    localparam logic [3:0] TY_UKPIN   = 4'h3;
    localparam logic [3:0] TY_STATIC  = 4'h4;
    localparam logic [3:0] TY_DERIVED = 4'h5;

    // bank kinds inside the store
    localparam logic [1:0] K_USER = 2'h0;
    localparam logic [1:0] K_ACC  = 2'h1;
    localparam logic [1:0] K_STAT = 2'h2;
    localparam logic [1:0] K_DER  = 2'h3;

    // rejection action codes
    localparam logic [3:0] RJ_ABORT  = 4'h1;
    localparam logic [3:0] RJ_AUTH   = 4'h2;
    localparam logic [3:0] RJ_CIPHER = 4'h3;

    // status bits
    localparam int ST_FOUND = 0;
    localparam int ST_NA    = 1;
    localparam int ST_REF   = 2;
    localparam int ST_PIN   = 3;

    typedef struct packed {
        logic [SEL_W-1:0]  sel;
        logic [3:0][31:0]  kin;
        logic [3:0][31:0]  kout;
        logic [3:0]        stat;
        logic              wreq;
        logic [31:0]       rdata;
        logic              abort;
        logic              retry_auth;
        logic              retry_elem;
    } state_t;

endpackage : key_store_pkg

// ### logic/key_store_indexer.sv
// key store: numbered key banks per identity and identity/park owner,
// with lookup, manual entry, allocation and authentication results.
// assumes an avalon-mm master that holds each request until it sees
// waitrequest low; key storage has no reset, like non-volatile memory.
//
// Notes on behaviour
// - separate user and access banks per owner
// - eight authentication keys per bank
// - key storage survives reset
// - personal pin never stored here
// - four-bit auth key type selector
// - number top bit picks owner bank
// - key-with-pin indexes user key part
// - allocation source access code number
// - allocated key written at destination number
// - separate static and derived banks per owner
// - eight cipher keys per bank
// - static manual only, derived by authentication
// - four-bit cipher type and number
// - cipher number top bit picks owner
// - store flag set writes derived key
// - store flag clear writes no derived key
// - derived write overwrites old slot
// - default flag writes default key slot
// - default write overwrites old slot
// - rejection codes abort or retry
// - key entries are 128 bits
// - allocation needs stored access code
// - no allocation path for roaming visitors
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps
module key_store_indexer
    import key_store_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // rejection actions toward the protocol layer
    output logic             access_abort,
    output logic             retry_auth_type,
    output logic             retry_element_a
);

    // slot index {ok, default, owner, kind, slot}; bad type gives ok 0
    // four-bit type and number fields decoded here
    function automatic logic [7:0] slot_of(input logic [3:0] t,
                                           input logic [3:0] n);
        logic       ok;
        logic [1:0] k;
        ok = 1'b1;
        k  = K_USER;
        case (t)
            TY_USER, TY_UKPIN: k = K_USER;
            TY_ACCESS:         k = K_ACC;
            TY_STATIC:         k = K_STAT;
            TY_DERIVED:        k = K_DER;
            default:           ok = 1'b0;
        endcase
        return {ok, 1'b0, n[3], k, n[2:0]};
    endfunction : slot_of

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[8*i +: 8] = n[8*i +: 8];
        end
        return r;
    endfunction : merge

    state_t           s_q;
    state_t           s_d;
    logic [KEY_W-1:0] key_mem [MEM_N];
    logic [MEM_N-1:0] key_ok;
    logic             req;
    logic             commit;
    logic             cmd_go;
    logic [3:0]       op;
    logic [3:0]       arg;
    logic [7:0]       sl;
    logic [7:0]       src;
    logic [7:0]       dst;
    logic [7:0]       der;
    logic [6:0]       dfl;
    logic             we1;
    logic [6:0]       wa1;
    logic             we2;
    logic             clr;
    logic             wipe;

    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = s_q.wreq;
    assign access_abort    = s_q.abort;
    assign retry_auth_type = s_q.retry_auth;
    assign retry_element_a = s_q.retry_elem;

    // fields decoded from the selector for every command
    assign sl  = slot_of(s_q.sel[SEL_TYPE +: 4], s_q.sel[SEL_NUM +: 4]);
    assign src = slot_of(TY_ACCESS, s_q.sel[SEL_NUM +: 4]);
    assign dst = slot_of(TY_USER, s_q.sel[SEL_DEST +: 4]);
    assign der = slot_of(TY_DERIVED, s_q.sel[SEL_NUM +: 4]);
    assign dfl = {4'h8, s_q.sel[SEL_DEFIX +: 3]};

    // bus handshake: one wait cycle, then the access completes
    assign req    = avs_read | avs_write;
    assign commit = req & ~s_q.wreq;
    assign cmd_go = commit & avs_write
                  & (avs_address[7:2] == OFS_CMD[7:2]);
    assign op     = avs_writedata[3:0];
    assign arg    = avs_writedata[7:4];

    // next state: register writes and command execution
    always_comb begin
        s_d            = s_q;
        s_d.wreq       = ~(req & s_q.wreq);
        s_d.abort      = 1'b0;
        s_d.retry_auth = 1'b0;
        s_d.retry_elem = 1'b0;
        we1            = 1'b0;
        wa1            = sl[6:0];
        we2            = 1'b0;
        clr            = 1'b0;
        wipe           = 1'b0;
        // read data is loaded during the wait cycle and then held
        if (req & s_q.wreq) begin
            s_d.rdata = 32'h0000_0000;
            if (avs_address[7:2] == OFS_SEL[7:2]) begin
                s_d.rdata[SEL_W-1:0] = s_q.sel;
            end else if (avs_address[7:2] == OFS_STAT[7:2]) begin
                s_d.rdata[3:0] = s_q.stat;
            end else if (avs_address[7:4] == PAGE_KIN) begin
                s_d.rdata = s_q.kin[avs_address[3:2]];
            end else if (avs_address[7:4] == PAGE_KOUT) begin
                s_d.rdata = s_q.kout[avs_address[3:2]];
            end
        end
        // plain register writes; unmapped writes are dropped
        if (commit & avs_write) begin
            if (avs_address[7:2] == OFS_SEL[7:2]) begin
                s_d.sel = SEL_W'(merge(32'(s_q.sel), avs_writedata,
                                       avs_byteenable));
            end else if (avs_address[7:4] == PAGE_KIN) begin
                s_d.kin[avs_address[3:2]] =
                    merge(s_q.kin[avs_address[3:2]], avs_writedata,
                          avs_byteenable);
            end
        end
        // commands act in the cycle the write completes
        if (cmd_go) begin
            s_d.stat[ST_REF] = 1'b0;
            case (op)
                OP_LOOKUP: begin
                    // pin is supplied fresh by the caller every time
                    s_d.stat[ST_PIN] =
                        (s_q.sel[SEL_TYPE +: 4] == TY_UKPIN);
                    if (sl[7] && key_ok[sl[6:0]]) begin
                        s_d.kout = key_mem[sl[6:0]];
                        s_d.stat[ST_FOUND] = 1'b1;
                        s_d.stat[ST_NA]    = 1'b0;
                    end else begin
                        s_d.kout = '0;
                        s_d.stat[ST_FOUND] = 1'b0;
                        s_d.stat[ST_NA]    = 1'b1;
                    end
                end
                OP_STORE: begin
                    // manual entry; derived keys only come from auth
                    if (sl[7] && sl[4:3] != K_DER) begin
                        we1 = 1'b1;
                    end else begin
                        s_d.stat[ST_REF] = 1'b1;
                    end
                end
                OP_ERASE: begin
                    clr = sl[7];
                    s_d.stat[ST_REF] = ~sl[7];
                end
                OP_ALLOC: begin
                    // only a stored access code may seed a user key;
                    // there is no path for visitor keys here
                    if (key_ok[src[6:0]]) begin
                        we1 = 1'b1;
                        wa1 = dst[6:0];
                    end else begin
                        s_d.stat[ST_REF] = 1'b1;
                    end
                end
                OP_AUTH: begin
                    we1 = s_q.sel[SEL_STORE];
                    wa1 = der[6:0];
                    we2 = s_q.sel[SEL_DEF];
                end
                OP_WIPE: wipe = 1'b1;
                OP_REJECT: begin
                    s_d.abort      = (arg == RJ_ABORT);
                    s_d.retry_auth = (arg == RJ_AUTH);
                    s_d.retry_elem = (arg == RJ_CIPHER);
                    s_d.stat[ST_REF] = (arg == 4'h0) | (arg > RJ_CIPHER);
                end
                default: s_d.stat[ST_REF] = 1'b1;
            endcase
        end
    end

    // control state
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q      <= '0;
            s_q.wreq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // key storage deliberately has no reset so it behaves like
    // non-volatile memory; software must wipe it after power-up
    always_ff @(posedge core_clk) begin
        if (wipe) begin
            key_ok <= '0;
        end else if (clr) begin
            key_ok[sl[6:0]] <= 1'b0;
        end
        if (we1) begin
            key_mem[wa1] <= s_q.kin;
            key_ok[wa1]  <= 1'b1;
        end
        if (we2) begin
            key_mem[dfl] <= s_q.kin;
            key_ok[dfl]  <= 1'b1;
        end
    end

    // assertions
    AST_WAIT_DROP: assert property (@(posedge core_clk) disable iff (!nrst)
        req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest did not drop after one cycle");

    AST_WAIT_RISE: assert property (@(posedge core_clk) disable iff (!nrst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    AST_NO_STORE: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_go && op == OP_AUTH && !s_q.sel[SEL_STORE] |-> !we1)
        else $error("derived key written with store flag clear");

    AST_DER_SLOT: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_go && op == OP_AUTH && s_q.sel[SEL_STORE]
        |-> we1 && wa1 == {1'b0, s_q.sel[SEL_NUM+3], K_DER,
                           s_q.sel[SEL_NUM +: 3]})
        else $error("derived key not written to its slot");

    AST_DEF_SLOT: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_go && op == OP_AUTH && s_q.sel[SEL_DEF]
        |=> key_ok[$past(dfl)])
        else $error("default key slot not filled");

    AST_ALLOC_GATE: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_go && op == OP_ALLOC && !key_ok[src[6:0]]
        |-> !we1 ##1 s_q.stat[ST_REF])
        else $error("allocation without stored access code");

    AST_NOT_AVAIL: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_go && op == OP_LOOKUP && !(sl[7] && key_ok[sl[6:0]])
        |=> s_q.stat[ST_NA] && !s_q.stat[ST_FOUND]
            && s_q.kout == '0)
        else $error("empty slot lookup returned key data");

    AST_PIN_PART: assert property (@(posedge core_clk) disable iff (!nrst)
        s_q.sel[SEL_TYPE +: 4] == TY_UKPIN
        |-> sl[4:3] == K_USER && sl[7])
        else $error("key-with-pin not mapped to user key bank");

    AST_STATIC: assert property (@(posedge core_clk) disable iff (!nrst)
        we1 && wa1[4:3] == K_DER |-> op == OP_AUTH && cmd_go)
        else $error("derived bank written outside authentication");

    AST_REJECT: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_go && op == OP_REJECT && arg == RJ_ABORT
        |=> access_abort && !retry_auth_type && !retry_element_a
        ##1 !access_abort)
        else $error("abort action not a single pulse");

endmodule : key_store_indexer

// ### verif/action_sink.sv
// partner model: protocol layer side that takes the rejection actions.
// assumes one-cycle pulses that are synchronous to core_clk.
`timescale 1ns/1ps
module action_sink
    import key_store_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // rejection actions
    input  wire logic       access_abort,
    input  wire logic       retry_auth_type,
    input  wire logic       retry_element_a,
    // what was seen
    output logic      [3:0] last_action,
    output logic      [7:0] n_actions
);
    // every high cycle counts, so a stretched pulse shows up as extra
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            last_action <= 4'h0;
            n_actions   <= 8'h00;
        end else if (access_abort | retry_auth_type | retry_element_a) begin
            last_action <= access_abort ? RJ_ABORT :
                           retry_auth_type ? RJ_AUTH : RJ_CIPHER;
            n_actions   <= n_actions + 8'h01;
        end
    end
endmodule : action_sink

// ### verif/key_store_indexer_tb.sv
// testbench: stores, looks up, allocates and authenticates keys over
// avalon-mm; assumes one-cycle waitrequest answers and no interrupts.
`timescale 1ns/1ps
module key_store_indexer_tb import key_store_pkg::*;;
    typedef struct packed {logic [3:0] ty; logic [3:0] num;
                           logic [3:0] st;} row_t;
    logic        core_clk, nrst, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address, n_actions;
    logic [31:0] avs_writedata, avs_readdata, rv;
    logic [3:0]  avs_byteenable, sv, last_action;
    logic        access_abort, retry_auth_type, retry_element_a;
    logic [127:0] kv;
    int          n_errors, total_checks;
    // both owner banks, boundary numbers, user, access and static kinds; access
    // codes are given as full 128-bit words, above 32 bits
    row_t rows [7] = '{'{TY_USER, 4'h0, 4'h1}, '{TY_USER, 4'h8, 4'h1},
        '{TY_ACCESS, 4'h0, 4'h1}, '{TY_ACCESS, 4'h8, 4'h1},
        '{TY_STATIC, 4'h7, 4'h1}, '{TY_STATIC, 4'hf, 4'h1},
        '{TY_USER, 4'h7, 4'h1}};

    key_store_indexer i_key_store_indexer (.core_clk(core_clk),
        .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .access_abort(access_abort),
        .retry_auth_type(retry_auth_type),
        .retry_element_a(retry_element_a));
    action_sink i_action_sink (.core_clk(core_clk), .nrst(nrst),
        .access_abort(access_abort), .retry_auth_type(retry_auth_type),
        .retry_element_a(retry_element_a), .last_action(last_action),
        .n_actions(n_actions));

    // distinct words per key so swapped words are seen
    function automatic logic [127:0] mk(input int i);
        return {32'h4444_0000 + 32'(i), 32'h3333_0000 + 32'(i),
                32'h2222_0000 + 32'(i), 32'h1111_0000 + 32'(i)};
    endfunction : mk
    function automatic logic [31:0] selw(input logic [3:0] t, n, d,
        input logic [2:0] x, input logic s, f);
        return {14'h0000, f, s, 1'b0, x, d, n, t};
    endfunction : selw
    task automatic chk(input string nm, input logic [127:0] e, g);
        total_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    // one avalon cycle; the request is held until waitrequest is low
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        // look at waitrequest mid-cycle, where it has settled, so the
        // completing rising edge is the one after a low sample
        do begin
            @(negedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            $display("CHECK FAILED waitrequest expected 0 seen 1");
            n_errors++;
        end
        q = avs_readdata;
        @(posedge core_clk); // completing edge: write lands here
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge core_clk); // no re-raise in the releasing time step
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000, rv);
    endtask : rd
    task automatic cmd(input logic [3:0] op, input logic [3:0] arg);
        wr(OFS_CMD, {24'h00_0000, arg, op});
    endtask : cmd
    task automatic put(input logic [127:0] k);
        for (int w = 0; w < 4; w++) wr({PAGE_KIN, 2'(w), 2'b00}, k[32*w+:32]);
    endtask : put
    task automatic look(input logic [3:0] t, input logic [3:0] n);
        wr(OFS_SEL, selw(t, n, 4'h0, 3'h0, 1'b0, 1'b0));
        cmd(OP_LOOKUP, 4'h0);
        for (int w = 0; w < 4; w++) begin
            rd({PAGE_KOUT, 2'(w), 2'b00});
            kv[32*w+:32] = rv;
        end
        rd(OFS_STAT);
        sv = rv[3:0];
    endtask : look
    task automatic auth(input logic [127:0] k, input logic [31:0] s);
        put(k);
        wr(OFS_SEL, s);
        cmd(OP_AUTH, 4'h0);
    endtask : auth
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up

    // free-running 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // watchdog: the whole sequence needs well under 20k cycles
    initial begin
        #400_000;
        n_errors = n_errors + 1;
        wrap_up;
    end
    // main sequence
    initial begin
        nrst = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        n_errors = 0;
        total_checks = 0;
        repeat (12) @(posedge core_clk);
        chk("reset waitrequest", 1'b1, avs_waitrequest);
        chk("reset abort", 1'b0, access_abort);
        nrst <= 1'b1;
        cmd(OP_WIPE, 4'h0); // storage is unknown until wiped
        foreach (rows[i]) begin
            wr(OFS_SEL, selw(rows[i].ty, rows[i].num, 4'h0, 3'h0, 0, 0));
            put(mk(i));
            cmd(OP_STORE, 4'h0);
        end
        // later stores must not clobber earlier slots of other banks
        foreach (rows[i]) begin
            look(rows[i].ty, rows[i].num);
            chk("row key", mk(i), kv);
            chk("row status", rows[i].st, sv);
        end
        look(TY_UKPIN, 4'h8);
        chk("pin key", mk(1), kv);
        chk("pin status", 4'h9, sv);
        look(TY_USER, 4'h3);
        chk("empty status", 4'h2, sv);
        chk("empty key", 128'h0, kv);
        look(4'h9, 4'h0);
        chk("bad type status", 4'h2, sv);
        wr(OFS_SEL, selw(TY_DERIVED, 4'h2, 4'h0, 3'h0, 0, 0));
        put(mk(8));
        cmd(OP_STORE, 4'h0);
        rd(OFS_STAT);
        chk("manual derived", 1'b1, rv[ST_REF]);
        auth(mk(9), selw(4'h0, 4'h2, 4'h0, 3'h0, 1, 0));
        look(TY_DERIVED, 4'h2);
        chk("derived stored", mk(9), kv);
        auth(mk(10), selw(4'h0, 4'h2, 4'h0, 3'h0, 1, 0));
        look(TY_DERIVED, 4'h2);
        chk("derived overwrite", mk(10), kv);
        auth(mk(11), selw(4'h0, 4'h2, 4'h0, 3'h5, 0, 1));
        look(TY_DERIVED, 4'h2);
        chk("derived kept", mk(10), kv);
        auth(mk(12), selw(4'h0, 4'ha, 4'h0, 3'h0, 1, 0));
        look(TY_DERIVED, 4'ha);
        chk("derived park", mk(12), kv);
        look(TY_DERIVED, 4'h2);
        chk("derived id", mk(10), kv);
        put(mk(13));
        wr(OFS_SEL, selw(4'h0, 4'h5, 4'h4, 3'h0, 0, 0));
        cmd(OP_ALLOC, 4'h0);
        rd(OFS_STAT);
        chk("alloc refused", 1'b1, rv[ST_REF]);
        look(TY_USER, 4'h4);
        chk("alloc no write", 4'h2, sv);
        put(mk(14));
        wr(OFS_SEL, selw(4'h0, 4'h0, 4'h9, 3'h0, 0, 0));
        cmd(OP_ALLOC, 4'h0);
        rd(OFS_STAT);
        chk("alloc taken", 1'b0, rv[ST_REF]);
        look(TY_USER, 4'h9);
        chk("alloc dest", mk(14), kv);
        for (int a = 1; a < 4; a++) begin
            cmd(OP_REJECT, 4'(a));
            @(posedge core_clk);
            chk("action", 4'(a), last_action);
            chk("action count", 8'(a), n_actions);
        end
        cmd(OP_REJECT, 4'h4);
        rd(OFS_STAT);
        chk("bad action", 1'b1, rv[ST_REF]);
        chk("bad action count", 8'h03, n_actions);
        rd(8'h40);
        chk("unmapped read", 32'h0, rv);
        rd(OFS_CMD);
        chk("command read", 32'h0, rv);
        // only the enabled byte lane of the selector may change
        avs_byteenable <= 4'h1;
        wr(OFS_SEL, 32'hffff_ffff);
        avs_byteenable <= 4'hf;
        rd(OFS_SEL);
        chk("byte lanes", 32'h0000_00ff, rv);
        // erase empties one slot only
        wr(OFS_SEL, selw(TY_USER, 4'h0, 4'h0, 3'h0, 0, 0));
        cmd(OP_ERASE, 4'h0);
        look(TY_USER, 4'h0);
        chk("erased status", 4'h2, sv);
        look(TY_USER, 4'h7);
        chk("erase neighbour", mk(6), kv);
        cmd(4'h8, 4'h0);
        rd(OFS_STAT);
        chk("bad opcode", 1'b1, rv[ST_REF]);
        // second reset: registers clear, key storage stays
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rd(OFS_SEL);
        chk("selector reset", 32'h0, rv);
        look(TY_USER, 4'h9);
        chk("kept user", mk(14), kv);
        look(TY_STATIC, 4'hf);
        chk("kept static", mk(5), kv);
        wrap_up;
    end
endmodule : key_store_indexer_tb
